// >>> pga_pkg.sv
// Notes on behaviour
// - latch six bits wide, five on narrow
// - narrow parts: bit five reads zero
// - direction bits seven, six read zero
// - direction one floats pin, zero drives
// - data read returns pins, write latches
// - set and clear port writes are read-modify-write
// - bit four open drain, Schmitt input
// - bit four feeds timer0 external clock
// - other pins push-pull, TTL inputs
// - analog config field picks analog pins
// - config field three bits, msb optional
// - after power-on analog pins read zero
// - direction still drives analog pins
// - bit three reference, bit five select
// - enabled peripheral pin is not GPIO
// - resets make inputs; low latch kept
package pga_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int PIN_W  = 6;
  localparam int CFG_W  = 3;

  // register indices; byte address is four times the index
  localparam logic [7:0] DATA_IDX  = 8'h05;
  localparam logic [7:0] DIR_IDX   = 8'h85;
  localparam logic [7:0] CFG_IDX   = 8'h9f;
  localparam logic [7:0] SET_IDX   = 8'h40;
  localparam logic [7:0] CLR_IDX   = 8'h41;

  localparam logic [ADDR_W-1:0] DATA_ADDR = {DATA_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] DIR_ADDR  = {DIR_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CFG_ADDR  = {CFG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] SET_ADDR  = {SET_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CLR_ADDR  = {CLR_IDX, 2'b00};

  localparam int OD_BIT   = 4;
  localparam int VREF_BIT = 3;
  localparam int SS_BIT   = 5;

  localparam logic [PIN_W-1:0] IMPL_WIDE   = 6'h3f;
  localparam logic [PIN_W-1:0] IMPL_NARROW = 6'h1f;
  localparam logic [PIN_W-1:0] OD_MASK     = 6'h10;
  localparam logic [PIN_W-1:0] SS_MASK     = 6'h20;
  localparam logic [PIN_W-1:0] DIR_RESET   = 6'h3f;
  localparam logic [PIN_W-1:0] LATCH_RESET = 6'h00;
  localparam logic [CFG_W-1:0] CFG_RESET   = 3'h0;
  localparam logic [CFG_W-1:0] CFG_MSB     = 3'h4;
  localparam logic [CFG_W-1:0] CFG_DIGITAL = 3'h7;

  // analog pin mask per config value, index 7 first
  localparam logic [7:0][PIN_W-1:0] ANALOG_MAP = {
    6'h00, 6'h00, 6'h0b, 6'h0b, 6'h0b, 6'h0f, 6'h2f, 6'h2f
  };
  // config values that turn bit three into the reference input
  localparam logic [7:0] VREF_MAP = 8'h2a;

  typedef enum logic [1:0] {
    PGA_IDLE   = 2'b00,
    PGA_ANSWER = 2'b01
  } pga_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
  } pga_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } pga_apb_rsp_t;

endpackage : pga_pkg

// >>> pga_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pga_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pga_sync
`default_nettype wire

// >>> pga_port_a.sv
`timescale 1ns/10ps
`default_nettype none
module pga_port_a #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  // clock and resets
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  warmReset,
  // register bus
  input  wire pga_pkg::pga_apb_req_t apbReq,
  output var  pga_pkg::pga_apb_rsp_t apbRsp,
  // pads
  input  wire logic [5:0]            padIn,
  output var  logic [5:0]            padOut,
  output var  logic [5:0]            padOeN,
  // peripheral sharing
  input  wire logic                  ssPortEnable,
  output var  logic                  timer0ExternalClockIn,
  output var  logic                  ssSelectIn,
  output var  logic [5:0]            analogPinMask,
  output var  logic                  vrefEnable
);
  import pga_pkg::*;

  localparam logic [PIN_W-1:0] IMPL = WIDE_VARIANT ? IMPL_WIDE : IMPL_NARROW;
  localparam logic [CFG_W-1:0] CFG_IMPL =
    WIDE_VARIANT ? 3'h7 : 3'h3;

  pga_state_t       state_q, state_d;
  pga_apb_rsp_t     rsp_q, rsp_d;
  logic [PIN_W-1:0] latch_q, latch_d;
  logic [PIN_W-1:0] dir_q, dir_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [PIN_W-1:0] padOut_q, padOut_d;
  logic [PIN_W-1:0] padOeN_q, padOeN_d;
  logic             timerClk_q;
  logic             ssSel_q;
  logic [PIN_W-1:0] analog_q, analog_d;
  logic             vref_q, vref_d;
  logic [PIN_W-1:0] pinSync;

  pga_sync #(.W(PIN_W)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (padIn),
    .q     (pinSync)
  );

  // bus decode
  wire              setupPhase = apbReq.psel & ~apbReq.penable;
  wire              taken      = apbReq.psel & apbReq.penable &
                                 rsp_q.pready;
  wire              lane0      = apbReq.pstrb[0];
  wire              hitData    = apbReq.paddr == DATA_ADDR;
  wire              hitDir     = apbReq.paddr == DIR_ADDR;
  wire              hitCfg     = apbReq.paddr == CFG_ADDR;
  wire              hitSet     = apbReq.paddr == SET_ADDR;
  wire              hitClr     = apbReq.paddr == CLR_ADDR;
  wire              hitAny     = hitData | hitDir | hitCfg |
                                 hitSet | hitClr;
  wire              wrTaken    = taken & apbReq.pwrite & ~warmReset;
  wire [PIN_W-1:0]  wrBits     = apbReq.pwdata[PIN_W-1:0];

  wire [PIN_W-1:0]  analogMask = ANALOG_MAP[cfg_q] & IMPL & ~OD_MASK;
  // enabled select input takes bit five away from GPIO
  wire [PIN_W-1:0]  ssBlock    = (ssPortEnable & WIDE_VARIANT) ?
                                 SS_MASK : 6'h00;
  // analog and borrowed pins read zero
  wire [PIN_W-1:0]  digitalRd  = pinSync & IMPL & ~analogMask & ~ssBlock;
  // set and clear writes store sampled pins with the modification; data writes store the written bits
  wire [PIN_W-1:0]  rmwData    = lane0 ? wrBits : digitalRd;
  wire [PIN_W-1:0]  rmwSet     = digitalRd | (lane0 ? wrBits : 6'h00);
  wire [PIN_W-1:0]  rmwClr     = digitalRd & ~(lane0 ? wrBits : 6'h00);

  // data read shows pins, not the latch
  // absent and upper bits read zero
  wire [DATA_W-1:0] rdMux =
    (hitData | hitSet | hitClr) ? {26'h0, digitalRd} :
    hitDir                      ? {26'h0, dir_q & IMPL} :
    hitCfg                      ? {29'h0, cfg_q & CFG_IMPL} :
                                  32'h0;

  // bus answer: no wait state, read data comes from a flop loaded in the setup phase
  always_comb begin
    state_d = state_q;
    rsp_d   = rsp_q;
    case (state_q)
      PGA_IDLE: begin
        if (setupPhase) begin
          state_d       = PGA_ANSWER;
          rsp_d.pready  = 1'b1;
          rsp_d.pslverr = ~hitAny;
          rsp_d.prdata  = apbReq.pwrite ? 32'h0 : rdMux;
        end
      end
      PGA_ANSWER: begin
        state_d = PGA_IDLE;
        rsp_d   = '0;
      end
      default: begin
        state_d = PGA_IDLE;
        rsp_d   = '0;
      end
    endcase
  end

  // register writes and warm reset
  always_comb begin
    latch_d = latch_q;
    dir_d   = dir_q;
    cfg_d   = cfg_q;
    if (warmReset) begin
      dir_d = DIR_RESET & IMPL;
      cfg_d = CFG_RESET;
    end else if (wrTaken) begin
      if (hitData) latch_d = rmwData & IMPL;
      if (hitSet)  latch_d = rmwSet & IMPL;
      if (hitClr)  latch_d = rmwClr & IMPL;
      if (hitDir && lane0) dir_d = wrBits & IMPL;
      if (hitCfg && lane0) cfg_d = apbReq.pwdata[CFG_W-1:0] & CFG_IMPL;
    end
  end

  // pad drivers from the next register values
  always_comb begin
    // direction gates the driver, analog or not
    // push-pull pins drive the latch level
    padOut_d = latch_d & ~OD_MASK & IMPL;
    padOeN_d = dir_d | ~IMPL | ssBlock;
    padOeN_d[OD_BIT] = dir_d[OD_BIT] | latch_d[OD_BIT];
  end

  assign analog_d = ANALOG_MAP[cfg_d] & IMPL & ~OD_MASK;
  assign vref_d   = VREF_MAP[cfg_d];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q    <= PGA_IDLE;
      rsp_q      <= '0;
      latch_q    <= LATCH_RESET;
      dir_q      <= DIR_RESET & IMPL;
      cfg_q      <= CFG_RESET;
      padOut_q   <= LATCH_RESET;
      padOeN_q   <= DIR_RESET;
      timerClk_q <= 1'b0;
      ssSel_q    <= 1'b0;
      analog_q   <= ANALOG_MAP[CFG_RESET] & IMPL & ~OD_MASK;
      vref_q     <= VREF_MAP[CFG_RESET];
    end else begin
      state_q    <= state_d;
      rsp_q      <= rsp_d;
      latch_q    <= latch_d;
      dir_q      <= dir_d;
      cfg_q      <= cfg_d;
      padOut_q   <= padOut_d;
      padOeN_q   <= padOeN_d;
      timerClk_q <= pinSync[OD_BIT];
      ssSel_q    <= pinSync[SS_BIT] & WIDE_VARIANT;
      analog_q   <= analog_d;
      vref_q     <= vref_d;
    end
  end

  assign apbRsp                = rsp_q;
  assign padOut                = padOut_q;
  assign padOeN                = padOeN_q;
  assign timer0ExternalClockIn = timerClk_q;
  assign ssSelectIn            = ssSel_q;
  assign analogPinMask         = analog_q;
  assign vrefEnable            = vref_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_dir_float: assert property (
    ((dir_q & IMPL) & ~padOeN_q) == 6'h00)
    else $error("pin driven while direction is input");

  // drives latch when direction is zero
  chk_push_pull: assert property (
    ((padOut_q ^ latch_q) & ~dir_q & ~ssBlock & IMPL & ~OD_MASK) == 6'h00)
    else $error("push-pull pin differs from latch");

  chk_open_drain: assert property (
    !padOut_q[OD_BIT] &&
      (padOeN_q[OD_BIT] || (!latch_q[OD_BIT] && !dir_q[OD_BIT])))
    else $error("open-drain pin misbehaves");

  chk_timer_route: assert property (
    ##1 timer0ExternalClockIn == $past(pinSync[OD_BIT]))
    else $error("timer0 clock not routed from bit four");

  chk_rmw_set: assert property (
    (wrTaken && hitSet && lane0) |=>
      latch_q == (($past(digitalRd) | $past(wrBits)) & IMPL))
    else $error("read-modify-write set lost pin state");

  // warm reset sets all inputs, keeps latch
  chk_warm_reset: assert property (
    warmReset |=> (dir_q == (DIR_RESET & IMPL)) && cfg_q == CFG_RESET &&
      $stable(latch_q))
    else $error("warm reset values wrong");

  chk_analog_zero: assert property (
    (setupPhase && state_q == PGA_IDLE && !apbReq.pwrite && hitData) |=>
      (rsp_q.prdata[PIN_W-1:0] & $past(analogMask)) == 6'h00)
    else $error("analog pin read nonzero");

  // upper bits always zero in answers
  chk_upper_zero: assert property (
    rsp_q.pready |-> rsp_q.prdata[DATA_W-1:PIN_W] == 26'h0)
    else $error("unimplemented bits read nonzero");

  chk_read_pins: assert property (
    (setupPhase && state_q == PGA_IDLE && !apbReq.pwrite && hitData &&
      cfg_q == CFG_DIGITAL && !ssPortEnable) |=>
      rsp_q.prdata[PIN_W-1:0] == ($past(pinSync) & IMPL))
    else $error("data read does not show pins");

  chk_ready_pulse: assert property (
    setupPhase |=> rsp_q.pready ##1 !rsp_q.pready)
    else $error("bus answer timing wrong");

  chk_latch_width: assert property (
    (latch_q & ~IMPL) == 6'h00)
    else $error("latch holds an absent bit");

  chk_absent_zero: assert property (
    rsp_q.pready |-> ((rsp_q.prdata[PIN_W-1:0] & ~IMPL) == 6'h00))
    else $error("absent pin bit read nonzero");

  chk_cfg_width: assert property (
    (cfg_q & ~CFG_IMPL) == 3'h0)
    else $error("config holds an absent bit");

  chk_analog_map: assert property (
    analogPinMask == (ANALOG_MAP[cfg_q] & IMPL & ~OD_MASK))
    else $error("analog pin mask does not follow config");

  chk_vref_map: assert property (
    vrefEnable == VREF_MAP[cfg_q])
    else $error("reference enable does not follow config");

  chk_select_route: assert property (
    ##1 ssSelectIn == ($past(pinSync[SS_BIT]) && WIDE_VARIANT))
    else $error("select input not routed from bit five");

  chk_ss_release: assert property (
    ssPortEnable |=> padOeN_q[SS_BIT])
    else $error("select pin driven while serial port owns it");

  chk_analog_drive: assert property (
    ((padOeN_q ^ dir_q) & analogPinMask & ~SS_MASK) == 6'h00)
    else $error("analog pin driver ignores direction");

  chk_rmw_clear: assert property (
    (wrTaken && hitClr && lane0) |=>
      latch_q == (($past(digitalRd) & ~$past(wrBits)) & IMPL))
    else $error("read-modify-write clear lost pin state");

  chk_write_latch: assert property (
    (wrTaken && hitData && lane0) |=> latch_q == ($past(wrBits) & IMPL))
    else $error("data write did not reach the latch");

  // two edges of pin latency
  // reset term masks the edges when the stages were still cleared
  chk_pins_synced: assert property (
    ##2 ($past(reset, 2) || pinSync == $past(padIn, 2)))
    else $error("pin synchroniser latency wrong");

  chk_warm_ignore: assert property (
    (warmReset && taken && apbReq.pwrite) |=> $stable(latch_q))
    else $error("write landed during warm reset");

  cov_data_write: cover property (wrTaken && hitData);
  cov_warm_write: cover property (warmReset && taken && apbReq.pwrite);
  cov_set_write: cover property (wrTaken && hitSet);
  cov_analog_read: cover property (taken && hitData && cfg_q == CFG_RESET);
  cov_ss_enabled: cover property (ssPortEnable && taken && hitData);

endmodule : pga_port_a
`default_nettype wire

// >>> pga_port_a_end.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> pga_pins.sv
`timescale 1ns/10ps
`default_nettype none
module pga_pins (
  // device side
  input  wire logic [5:0] padOut,
  input  wire logic [5:0] padOeN,
  output var  logic [5:0] padIn,
  // board drivers
  input  wire logic [5:0] extVal,
  input  wire logic [5:0] extOe
);
  // open drain needs the pull-up
  // board pull-ups everywhere, so a released pin never floats
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      padIn[i] = !padOeN[i] ? padOut[i] : (extOe[i] ? extVal[i] : 1'h1);
    end
  end
endmodule : pga_pins
`default_nettype wire

// >>> test_port_a_pin_logic.sv
`timescale 1ns/10ps
`default_nettype none
module test_port_a_pin_logic;
  import pga_pkg::*;
  logic         clk = 0, reset = 1, warmReset = 0, ssPortEnable = 0;
  pga_apb_req_t apbReq = '0;
  pga_apb_rsp_t apbRsp;
  logic [5:0]   padIn, padOut, padOeN, analogPinMask;
  logic [5:0]   extVal = 6'h3f, extOe = 6'h3f;
  logic         t0Clk, ssIn, vrefEnable, err;
  logic [31:0]  rd;
  int           nFail = 0, checks = 0;

  always #20 clk = ~clk;

  pga_port_a #(.WIDE_VARIANT(1'h1)) i_dut (
    .clk(clk), .reset(reset), .warmReset(warmReset),
    .apbReq(apbReq), .apbRsp(apbRsp),
    .padIn(padIn), .padOut(padOut), .padOeN(padOeN),
    .ssPortEnable(ssPortEnable), .timer0ExternalClockIn(t0Clk),
    .ssSelectIn(ssIn), .analogPinMask(analogPinMask),
    .vrefEnable(vrefEnable)
  );
  pga_pins i_pins (
    .padOut(padOut), .padOeN(padOeN), .padIn(padIn),
    .extVal(extVal), .extOe(extOe)
  );

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      nFail++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", checks, nFail);
    if (nFail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // entered just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [9:0] a,
                     input logic [31:0] wd);
    apbReq.psel    <= 1'h1;
    apbReq.penable <= 1'h0;
    apbReq.pwrite  <= wr;
    apbReq.paddr   <= a;
    apbReq.pwdata  <= wd;
    apbReq.pstrb   <= 4'hf;
    @(posedge clk);
    apbReq.penable <= 1'h1;
    // no local timeout: pready ends this wait, or else the watchdog
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'h1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel    <= 1'h0;
    apbReq.penable <= 1'h0;
    // idle edge, so a next call never re-drives psel in this step
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(rd, e);
  endtask : rdchk

  // two synchroniser stages plus registered outputs
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    settle();
    rdchk(DIR_ADDR, 32'h3f);
    rdchk(CFG_ADDR, 32'h0);
    rdchk(DATA_ADDR, 32'h10);
    check(analogPinMask, 32'h2f);
    apb(1'h1, CFG_ADDR, 32'h7);
    rdchk(CFG_ADDR, 32'h7);
    extVal <= 6'h2a;
    settle();
    rdchk(DATA_ADDR, 32'h2a);
    check(t0Clk, 32'h0);
    extVal <= 6'h3f;
    ssPortEnable <= 1'h1;
    settle();
    rdchk(DATA_ADDR, 32'h1f);
    check(ssIn, 32'h1);
    check(t0Clk, 32'h1);
    ssPortEnable <= 1'h0;
    apb(1'h1, DIR_ADDR, 32'hff);
    rdchk(DIR_ADDR, 32'h3f);
    apb(1'h1, DIR_ADDR, 32'h0);
    extOe <= 6'h0;
    apb(1'h1, DATA_ADDR, 32'h15);
    settle();
    check(padOeN, 32'h10);
    rdchk(DATA_ADDR, 32'h15);
    apb(1'h1, DATA_ADDR, 32'h05);
    settle();
    check(padOeN, 32'h0);
    check(padOut, 32'h05);
    // bit one as input, held high by the board, latch holds zero there
    apb(1'h1, DIR_ADDR, 32'h02);
    extOe <= 6'h02;
    settle();
    apb(1'h1, SET_ADDR, 32'h08);
    apb(1'h1, DIR_ADDR, 32'h0);
    extOe <= 6'h0;
    settle();
    rdchk(DATA_ADDR, 32'h0f);
    apb(1'h1, CLR_ADDR, 32'h01);
    settle();
    rdchk(DATA_ADDR, 32'h0e);
    apb(1'h1, 10'h3f0, 32'h1);
    check({rd[30:0], err}, 32'h1);
    apb(1'h1, DIR_ADDR, 32'h3f);
    for (int k = 0; k < 8; k++) begin
      // config first: the analog set only shrinks along the loop
      apb(1'h1, CFG_ADDR, 32'(k));
      // analog pins stay inputs, the rest drive the latch
      apb(1'h1, DIR_ADDR, 32'(ANALOG_MAP[k]));
      settle();
      check(analogPinMask, ANALOG_MAP[k]);
      check(vrefEnable, VREF_MAP[k]);
      check(padOeN, 32'(ANALOG_MAP[k]));
      rdchk(DATA_ADDR, 6'h0e & ~ANALOG_MAP[k]);
    end
    warmReset <= 1'h1;
    // a write while warm reset holds must leave the latch alone
    apb(1'h1, DATA_ADDR, 32'h3f);
    warmReset <= 1'h0;
    @(posedge clk);
    rdchk(DIR_ADDR, 32'h3f);
    rdchk(CFG_ADDR, 32'h0);
    apb(1'h1, CFG_ADDR, 32'h7);
    apb(1'h1, DIR_ADDR, 32'h0);
    settle();
    rdchk(DATA_ADDR, 32'h0e);
    results();
  end

  initial begin
    #2000000;
    nFail++;
    $display("Error at %0t: run timed out", $time);
    results();
  end
endmodule : test_port_a_pin_logic
`default_nettype wire
